// *** pkg/amc_pkg.sv ***
// shared codes, element lengths and helpers for the auth message codec
package amc_pkg;

  localparam logic [7:0] MT_REQUEST  = 8'h40;
  localparam logic [7:0] MT_REPLY    = 8'h41;
  localparam int         MT_MSB_POS  = 7;

  localparam logic [7:0] ID_TYPE     = 8'h0a;
  localparam logic [7:0] ID_CHAL     = 8'h0c;
  localparam logic [7:0] ID_RESP     = 8'h0d;
  localparam logic [7:0] ID_SEED     = 8'h0e;

  localparam logic [4:0] HDR_LEN     = 5'h02;
  localparam logic [4:0] LEN_TYPE    = 5'h05;
  localparam logic [4:0] LEN_CHAL    = 5'h0a;
  localparam logic [4:0] LEN_RESP    = 5'h06;
  localparam logic [4:0] LEN_SEED1   = 5'h0a;
  localparam logic [4:0] LEN_SEED2   = 5'h12;

  localparam logic [1:0] ERR_TYPE    = 2'h0;
  localparam logic [1:0] ERR_ID      = 2'h1;
  localparam logic [1:0] ERR_LEN     = 2'h2;
  localparam logic [1:0] ERR_MISSING = 2'h3;

  typedef enum logic [1:0] {
    EL_TYPE = 2'b00,
    EL_CHAL = 2'b01,
    EL_RESP = 2'b10,
    EL_SEED = 2'b11
  } amc_elem_e;

  function automatic logic [7:0] el_id(amc_elem_e k);
    case (k)
      EL_CHAL: el_id = ID_CHAL;
      EL_RESP: el_id = ID_RESP;
      EL_SEED: el_id = ID_SEED;
      default: el_id = ID_TYPE;
    endcase
  endfunction

  function automatic logic [4:0] el_total(amc_elem_e k, logic alg2);
    case (k)
      EL_CHAL: el_total = LEN_CHAL;
      EL_RESP: el_total = LEN_RESP;
      EL_SEED: el_total = alg2 ? LEN_SEED2 : LEN_SEED1;
      default: el_total = LEN_TYPE;
    endcase
  endfunction

endpackage

// *** pkg/amc_link_if.sv ***
// byte stream carrying one auth message per frame, builder to parser
`timescale 1ns/1ps
interface amc_link_if (
  input wire logic CLK
);
  logic [7:0] data;
  logic       valid;
  logic       ready;
  logic       last;

  modport builder (output data, output valid, output last, input ready);
  modport parser  (input data, input valid, input last, output ready);
endinterface

// *** design/amc_elem_byte.sv ***
// one octet of an element: identifier, length indicator or value byte
`timescale 1ns/1ps
module amc_elem_byte (
  input  wire amc_pkg::amc_elem_e  kind,
  input  wire logic                alg2,
  input  wire logic [23:0]         auth_type,
  input  wire logic [63:0]         chal,
  input  wire logic [31:0]         resp,
  input  wire logic [127:0]        seed,
  input  wire logic [4:0]          idx,
  output logic [7:0]               byte_o,
  output logic                     last_o
);
  logic [4:0]   total_w;
  logic [4:0]   vidx_w;
  logic [7:0]   len_w;
  logic [127:0] value_w;
  logic [127:0] shifted_w;

  assign total_w   = amc_pkg::el_total(kind, alg2);
  // value right aligned; a short seed drops its upper half
  assign value_w   = (kind == amc_pkg::EL_CHAL) ? {64'h0, chal}
                   : (kind == amc_pkg::EL_RESP) ? {96'h0, resp}
                   : (kind == amc_pkg::EL_SEED) ? (alg2 ? seed : {64'h0, seed[63:0]})
                   : {104'h0, auth_type};
  // octet 3 carries the top byte, the final octet the bottom one
  assign vidx_w    = total_w - 5'd1 - idx;
  assign shifted_w = value_w >> {vidx_w, 3'h0};
  // length octet counts value octets only
  assign len_w     = {3'h0, total_w - amc_pkg::HDR_LEN};
  assign byte_o    = (idx == 5'd0) ? amc_pkg::el_id(kind)
                   : (idx == 5'd1) ? len_w
                   : shifted_w[7:0];
  assign last_o    = (idx == total_w - 5'd1);
endmodule // amc_elem_byte

// *** design/amc_builder.sv ***
// message builder end: frames request and reply messages onto the link
`timescale 1ns/1ps
module amc_builder (
  input  wire logic         CLK,
  input  wire logic         RST_B,
  amc_link_if.builder       LINK,
  input  wire logic         START,
  input  wire logic         IS_REPLY,
  input  wire logic         FROM_FIXED,
  input  wire logic         ALG2,
  input  wire logic         KEY_ALLOC,
  input  wire logic [23:0]  AUTH_TYPE,
  input  wire logic [63:0]  CHALLENGE,
  input  wire logic [31:0]  RESPONSE,
  input  wire logic [127:0] SEED,
  output logic              BUSY,
  output logic              DONE
);
  typedef enum logic [1:0] {
    ENC_IDLE  = 2'b00,
    ENC_CODE  = 2'b01,
    ENC_ELEM  = 2'b10,
    ENC_DRAIN = 2'b11
  } amc_enc_e;

  amc_enc_e          state_q;
  logic              reply_q, fixed_q, alg2_q, kalloc_q;
  logic [23:0]       type_q;
  logic [63:0]       chal_q;
  logic [31:0]       resp_q;
  logic [127:0]      seed_q;
  logic [1:0]        slot_q;
  logic [4:0]        idx_q;
  logic [7:0]        data_q;
  logic              valid_q, last_q, busy_q, done_q;
  amc_pkg::amc_elem_e slot_kind [4];
  logic [1:0]        n_slots;
  amc_pkg::amc_elem_e cur_kind;
  logic [7:0]        byte_w, code_w;
  logic              el_last_w, final_w, adv;

  // element order per originator and message kind
  always_comb begin
    slot_kind[0] = amc_pkg::EL_TYPE;
    slot_kind[1] = amc_pkg::EL_CHAL;
    slot_kind[2] = amc_pkg::EL_RESP;
    slot_kind[3] = amc_pkg::EL_TYPE;
    n_slots      = 2'd2;
    case ({reply_q, fixed_q})
      2'b00: n_slots = kalloc_q ? 2'd3 : 2'd2;
      2'b01: begin
        slot_kind[1] = amc_pkg::EL_SEED;
        slot_kind[2] = amc_pkg::EL_CHAL;
        n_slots      = 2'd3;
      end
      2'b10: begin
        slot_kind[0] = amc_pkg::EL_RESP;
        slot_kind[1] = amc_pkg::EL_CHAL;
        n_slots      = alg2_q ? 2'd2 : 2'd1;
      end
      2'b11: begin
        slot_kind[0] = amc_pkg::EL_SEED;
        slot_kind[1] = amc_pkg::EL_RESP;
        slot_kind[2] = amc_pkg::EL_CHAL;
        n_slots      = alg2_q ? 2'd3 : 2'd2;
      end
      default: n_slots = 2'd2;
    endcase
  end

  assign cur_kind = slot_kind[slot_q];
  assign adv      = !valid_q || LINK.ready;
  assign final_w  = el_last_w && (slot_q == n_slots - 2'd1);
  // msb forced low whatever the code constant holds
  assign code_w   = {1'b0, reply_q ? amc_pkg::MT_REPLY[6:0] : amc_pkg::MT_REQUEST[6:0]};

  amc_elem_byte u_elem (
    .kind      (cur_kind),
    .alg2      (alg2_q),
    .auth_type (type_q),
    .chal      (chal_q),
    .resp      (resp_q),
    .seed      (seed_q),
    .idx       (idx_q),
    .byte_o    (byte_w),
    .last_o    (el_last_w)
  );

  // values held for the whole frame so a stalled link sees stable bytes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {reply_q, fixed_q, alg2_q, kalloc_q} <= 4'h0;
      type_q <= 24'h0;
      chal_q <= 64'h0;
      resp_q <= 32'h0;
      seed_q <= 128'h0;
    end else if (state_q == ENC_IDLE && START) begin
      {reply_q, fixed_q, alg2_q, kalloc_q} <= {IS_REPLY, FROM_FIXED, ALG2, KEY_ALLOC};
      type_q <= AUTH_TYPE;
      chal_q <= CHALLENGE;
      resp_q <= RESPONSE;
      seed_q <= SEED;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= ENC_IDLE;
      {slot_q, idx_q, data_q} <= 15'h0;
      {valid_q, last_q, busy_q, done_q} <= 4'h0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ENC_IDLE: if (START) begin
          busy_q  <= 1'b1;
          state_q <= ENC_CODE;
        end
        ENC_CODE: if (adv) begin
          data_q  <= code_w;
          valid_q <= 1'b1;
          slot_q  <= 2'd0;
          idx_q   <= 5'd0;
          state_q <= ENC_ELEM;
        end
        ENC_ELEM: if (adv) begin
          data_q  <= byte_w;
          last_q  <= final_w;
          slot_q  <= el_last_w ? slot_q + 2'd1 : slot_q;
          idx_q   <= el_last_w ? 5'd0 : idx_q + 5'd1;
          state_q <= final_w ? ENC_DRAIN : ENC_ELEM;
        end
        ENC_DRAIN: if (LINK.ready) begin
          {valid_q, last_q, busy_q} <= 3'h0;
          done_q  <= 1'b1;
          state_q <= ENC_IDLE;
        end
        default: state_q <= ENC_IDLE;
      endcase
    end
  end

  assign LINK.data  = data_q;
  assign LINK.valid = valid_q;
  assign LINK.last  = last_q;
  assign BUSY       = busy_q;
  assign DONE       = done_q;
endmodule // amc_builder

// *** design/amc_parser.sv ***
// message parser end: checks and unpacks auth messages from the link
// Notes on behaviour
// - reply code 01000001, request code distinct
// - message type msb always zero; the parser does not check it
// - portable request: type and challenge
// - fixed request: type, seed, challenge
// - reply contents depend on originator
// - response in request only from portable
// - seed 128 bits with second algorithm
// - challenge, response, seed identifier codes
// - type element identifier, five bytes total
// - element total lengths per algorithm
// - first algorithm msb-first value placement
// - second algorithm msb-first value placement
// - value starts at third octet
`timescale 1ns/1ps
module amc_parser (
  input  wire logic         CLK,
  input  wire logic         RST_B,
  amc_link_if.parser        LINK,
  input  wire logic         ALG2,
  output logic              MSG_VALID,
  output logic              MSG_ERROR,
  output logic [1:0]        ERR_CODE,
  output logic              IS_REPLY,
  output logic              FROM_FIXED,
  output logic [3:0]        HAS_ELEM,
  output logic [23:0]       AUTH_TYPE,
  output logic [63:0]       CHALLENGE,
  output logic [31:0]       RESPONSE,
  output logic [127:0]      SEED
);
  typedef enum logic [2:0] {
    DEC_TYPE = 3'b000,
    DEC_EID  = 3'b001,
    DEC_ELEN = 3'b010,
    DEC_BODY = 3'b011,
    DEC_SKIP = 3'b100
  } amc_dec_e;

  amc_dec_e           state_q, state_d;
  amc_pkg::amc_elem_e kind_q, kind_d, id_kind;
  logic [4:0]         rem_q, rem_d, exp_len;
  logic [127:0]       shift_q, shift_d;
  logic [3:0]         has_q, has_d, has_n;
  logic               reply_q, reply_d, ready_q;
  logic [1:0]         err_q, err_d;
  logic               err_hit, done_hit, valid_q, error_q;
  logic [23:0]        type_q;
  logic [63:0]        chal_q;
  logic [31:0]        resp_q;
  logic [127:0]       seed_q;
  logic               beat, type_ok, id_known, len_ok, body_end, msg_ok, store;
  logic [127:0]       seed_w;
  logic [7:0]         din;

  assign din      = LINK.data;
  assign beat     = LINK.valid && ready_q;
  // msb of the code is not looked at
  assign type_ok  = (din[6:0] == amc_pkg::MT_REQUEST[6:0])
                 || (din[6:0] == amc_pkg::MT_REPLY[6:0]);
  assign id_known = (din == amc_pkg::ID_TYPE) || (din == amc_pkg::ID_CHAL)
                 || (din == amc_pkg::ID_RESP) || (din == amc_pkg::ID_SEED);
  assign id_kind  = (din == amc_pkg::ID_CHAL) ? amc_pkg::EL_CHAL
                  : (din == amc_pkg::ID_RESP) ? amc_pkg::EL_RESP
                  : (din == amc_pkg::ID_SEED) ? amc_pkg::EL_SEED
                  : amc_pkg::EL_TYPE;
  // length octet counts value octets only
  assign exp_len  = amc_pkg::el_total(kind_q, ALG2) - amc_pkg::HDR_LEN;
  assign len_ok   = (din == {3'h0, exp_len});
  assign body_end = (rem_q == 5'd1);
  assign has_n    = has_q | (4'h1 << kind_q);

  // contents check by message kind; originator shows as a seed element
  assign msg_ok = reply_q
    ? (has_n[amc_pkg::EL_RESP] && !has_n[amc_pkg::EL_TYPE]
       && !(has_n[amc_pkg::EL_CHAL] && !ALG2))
    : (has_n[amc_pkg::EL_TYPE] && has_n[amc_pkg::EL_CHAL]
       && !(has_n[amc_pkg::EL_RESP] && has_n[amc_pkg::EL_SEED]));

  always_comb begin
    state_d  = state_q;
    kind_d   = kind_q;
    rem_d    = rem_q;
    shift_d  = shift_q;
    has_d    = has_q;
    reply_d  = reply_q;
    err_d    = err_q;
    err_hit  = 1'b0;
    done_hit = 1'b0;
    if (beat) begin
      case (state_q)
        DEC_TYPE: begin
          reply_d = din[0];
          has_d   = 4'h0;
          if (!type_ok) begin
            err_hit = 1'b1;
            err_d   = amc_pkg::ERR_TYPE;
          end else if (LINK.last) begin
            err_hit = 1'b1;
            err_d   = amc_pkg::ERR_MISSING;
          end else begin
            state_d = DEC_EID;
          end
        end
        DEC_EID: begin
          kind_d = id_kind;
          if (!id_known || LINK.last) begin
            err_hit = 1'b1;
            err_d   = id_known ? amc_pkg::ERR_LEN : amc_pkg::ERR_ID;
          end else begin
            state_d = DEC_ELEN;
          end
        end
        DEC_ELEN: begin
          rem_d = din[4:0];
          if (!len_ok || LINK.last) begin
            err_hit = 1'b1;
            err_d   = amc_pkg::ERR_LEN;
          end else begin
            state_d = DEC_BODY;
          end
        end
        DEC_BODY: begin
          // first value octet lands in the top of the value
          shift_d = {shift_q[119:0], din};
          rem_d   = rem_q - 5'd1;
          if (!body_end) begin
            if (LINK.last) begin
              err_hit = 1'b1;
              err_d   = amc_pkg::ERR_LEN;
            end
          end else begin
            has_d = has_n;
            if (!LINK.last) begin
              state_d = DEC_EID;
            end else if (msg_ok) begin
              done_hit = 1'b1;
            end else begin
              err_hit = 1'b1;
              err_d   = amc_pkg::ERR_MISSING;
            end
          end
        end
        DEC_SKIP: if (LINK.last) state_d = DEC_TYPE;
        default:  state_d = DEC_TYPE;
      endcase
    end
    // a bad frame is dropped up to its last octet
    if (err_hit) state_d = LINK.last ? DEC_TYPE : DEC_SKIP;
    if (done_hit) state_d = DEC_TYPE;
  end

  assign store  = beat && (state_q == DEC_BODY) && body_end;
  // a short seed keeps only its own eight octets
  assign seed_w = ALG2 ? shift_d : {64'h0, shift_d[63:0]};

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= DEC_TYPE;
      kind_q  <= amc_pkg::EL_TYPE;
      {rem_q, has_q, reply_q, err_q} <= 12'h0;
      shift_q <= 128'h0;
      {ready_q, valid_q, error_q} <= 3'h0;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      {rem_q, has_q, reply_q, err_q} <= {rem_d, has_d, reply_d, err_d};
      shift_q <= shift_d;
      ready_q <= 1'b1;
      valid_q <= done_hit;
      error_q <= err_hit;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      type_q <= 24'h0;
      chal_q <= 64'h0;
      resp_q <= 32'h0;
      seed_q <= 128'h0;
    end else if (store) begin
      case (kind_q)
        amc_pkg::EL_TYPE: type_q <= shift_d[23:0];
        amc_pkg::EL_CHAL: chal_q <= shift_d[63:0];
        amc_pkg::EL_RESP: resp_q <= shift_d[31:0];
        amc_pkg::EL_SEED: seed_q <= seed_w;
        default:          type_q <= type_q;
      endcase
    end
  end

  assign LINK.ready = ready_q;
  assign MSG_VALID  = valid_q;
  assign MSG_ERROR  = error_q;
  assign ERR_CODE   = err_q;
  assign IS_REPLY   = reply_q;
  assign FROM_FIXED = has_q[amc_pkg::EL_SEED];
  assign HAS_ELEM   = has_q;
  assign AUTH_TYPE  = type_q;
  assign CHALLENGE  = chal_q;
  assign RESPONSE   = resp_q;
  assign SEED       = seed_q;
endmodule // amc_parser

// *** bench/amc_link_chk.sv ***
// link protocol assertions for the auth message codec
`timescale 1ns/1ps
module amc_link_chk (
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic [7:0] data,
  input wire logic       valid,
  input wire logic       ready,
  input wire logic       last
);
  logic       sof_q;
  logic       id_q;
  logic       len_q;
  logic [7:0] eid_q;
  logic [7:0] rem_q;
  wire        hs = valid && ready;
  wire        val = !sof_q && !id_q && !len_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // walks the frame octet by octet: type code, then id, length, value runs
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sof_q <= 1'b1;
      id_q  <= 1'b0;
      len_q <= 1'b0;
      eid_q <= 8'h00;
      rem_q <= 8'h00;
    end else if (hs) begin
      sof_q <= last;
      id_q  <= sof_q || (val && rem_q == 8'h01);
      len_q <= !sof_q && id_q;
      eid_q <= id_q ? data : eid_q;
      rem_q <= len_q ? data : rem_q - 8'h01;
    end
  end

  property p_type;
    hs && sof_q |-> data == 8'h40 || data == 8'h41;
  endproperty
  a_type: assert property (p_type) else $error("bad type code");
  property p_msb;
    hs && sof_q |-> !data[7];
  endproperty
  a_msb: assert property (p_msb) else $error("type msb set");
  property p_id;
    hs && id_q && !sof_q |-> data inside {8'h0a, 8'h0c, 8'h0d, 8'h0e};
  endproperty
  a_id: assert property (p_id) else $error("bad identifier");
  // seed length is 8 or 16: the algorithm choice is not visible on the wire
  property p_len;
    hs && len_q |-> data == (eid_q == 8'h0a ? 8'h03 : eid_q == 8'h0d ? 8'h04 :
                             eid_q == 8'h0e && data == 8'h10 ? 8'h10 : 8'h08);
  endproperty
  a_len: assert property (p_len) else $error("bad length octet");
  property p_end;
    hs && last |-> val && rem_q == 8'h01;
  endproperty
  a_end: assert property (p_end) else $error("frame ends mid element");
  property p_run;
    hs && !last |=> valid;
  endproperty
  a_run: assert property (p_run) else $error("gap inside frame");
  property p_gap;
    hs && last |=> !valid [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("no idle after frame");
  property p_ready;
    $past(RST_B) |-> ready;
  endproperty
  a_ready: assert property (p_ready) else $error("parser stalled");

  c_reply: cover property (hs && sof_q && data == 8'h41);
  c_req: cover property (hs && sof_q && data == 8'h40);
  c_seed16: cover property (hs && len_q && data == 8'h10);
endmodule // amc_link_chk

// *** bench/tb.sv ***
// self-checking bench: builder and parser ends joined by one link
`timescale 1ns/1ps
module tb;
  localparam logic [23:0]  TYP = 24'h5a3c81;
  localparam logic [63:0]  CHL = 64'h0123456789abcdef;
  localparam logic [31:0]  RSP = 32'h8badf00d;
  localparam logic [127:0] SED = 128'hfedcba9876543210_0f1e2d3c4b5a6978;
  localparam logic [3:0]   CASES [8] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he};
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         start = 1'b0;
  logic [3:0]   cfg = 4'h0;
  logic         busy, done, ok_p, err_p, ok_b, err_b, r_rep, r_fix;
  logic [1:0]   ec_p, ec_b;
  logic [3:0]   r_has;
  logic [23:0]  r_typ;
  logic [63:0]  r_chl;
  logic [31:0]  r_rsp;
  logic [127:0] r_sed;
  logic [8:0]   got[$];
  logic [8:0]   exp[$];
  logic [7:0]   fr[$];
  int           ok_n = 0;
  int           err_n = 0;
  logic [1:0]   err_cd = 2'h0;
  int           mismatches = 0;
  int           checked = 0;

  amc_link_if lk (.CLK(clk));
  amc_link_if lk2 (.CLK(clk));

  amc_builder i_amc_builder (.CLK(clk), .RST_B(rst_b), .LINK(lk), .START(start),
    .IS_REPLY(cfg[3]), .FROM_FIXED(cfg[2]), .ALG2(cfg[1]), .KEY_ALLOC(cfg[0]),
    .AUTH_TYPE(TYP ^ {6{cfg}}), .CHALLENGE(CHL ^ {16{cfg}}), .RESPONSE(RSP ^ {8{cfg}}),
    .SEED(SED ^ {32{cfg}}), .BUSY(busy), .DONE(done));
  amc_parser i_amc_parser (.CLK(clk), .RST_B(rst_b), .LINK(lk), .ALG2(cfg[1]),
    .MSG_VALID(ok_p), .MSG_ERROR(err_p), .ERR_CODE(ec_p), .IS_REPLY(r_rep),
    .FROM_FIXED(r_fix), .HAS_ELEM(r_has), .AUTH_TYPE(r_typ), .CHALLENGE(r_chl),
    .RESPONSE(r_rsp), .SEED(r_sed));
  // second parser fed by the bench with broken frames
  amc_parser i_amc_parser_b (.CLK(clk), .RST_B(rst_b), .LINK(lk2), .ALG2(cfg[1]),
    .MSG_VALID(ok_b), .MSG_ERROR(err_b), .ERR_CODE(ec_b), .IS_REPLY(), .FROM_FIXED(),
    .HAS_ELEM(), .AUTH_TYPE(), .CHALLENGE(), .RESPONSE(), .SEED());
  amc_link_chk i_amc_link_chk (.CLK(clk), .RST_B(rst_b), .data(lk.data),
    .valid(lk.valid), .ready(lk.ready), .last(lk.last));

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (lk.valid === 1'b1 && lk.ready === 1'b1) got.push_back({lk.last, lk.data});
    if (ok_p === 1'b1 || ok_b === 1'b1) ok_n <= ok_n + 1;
    if (err_p === 1'b1 || err_b === 1'b1) begin
      err_n  <= err_n + 1;
      err_cd <= err_p === 1'b1 ? ec_p : ec_b;
    end
  end

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %0h expected %0h", $time, g, e);
    end
  endtask

  // value goes out msb first after id and length octets
  task automatic add_el(input logic [7:0] id, input int n, input logic [127:0] v);
    exp.push_back({1'b0, id});
    exp.push_back(n[8:0]);
    for (int i = n - 1; i >= 0; i--) exp.push_back({1'b0, v[i*8 +: 8]});
  endtask

  // c: reply, fixed side, second algorithm, key allocation
  task automatic send(input logic [3:0] c);
    logic [3:0] eh;
    int         ok0;
    int         er0;
    int         g0;
    int         n;
    eh = {c[2], c[3] | (c[0] & ~c[2]), ~c[3] | c[1], ~c[3]};
    exp = '{c[3] ? 9'h041 : 9'h040};
    // values differ per case so a stale element cannot pass
    if (!c[3]) add_el(8'h0a, 3, TYP ^ {6{c}});
    if (c[2]) add_el(8'h0e, c[1] ? 16 : 8, SED ^ {32{c}});
    if (c[3]) add_el(8'h0d, 4, RSP ^ {8{c}});
    if (!c[3] || c[1]) add_el(8'h0c, 8, CHL ^ {16{c}});
    if (!c[3] && !c[2] && c[0]) add_el(8'h0d, 4, RSP ^ {8{c}});
    exp[exp.size() - 1] = exp[exp.size() - 1] | 9'h100;
    @(posedge clk);
    ok0   = ok_n;
    er0   = err_n;
    g0    = got.size();
    cfg   <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 200 && done !== 1'b1; n++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk(n < 200, 1'b1);
    chk(got.size() - g0, exp.size());
    foreach (exp[i]) chk(got[g0 + i], exp[i]);
    chk({busy, r_rep, r_fix}, {1'b0, c[3:2]});
    chk(ok_n - ok0, 1);
    chk(err_n - er0, 0);
    chk(r_has, eh);
    if (eh[0]) chk(r_typ, TYP ^ {6{c}});
    if (eh[1]) chk(r_chl, CHL ^ {16{c}});
    if (eh[2]) chk(r_rsp, RSP ^ {8{c}});
    if (eh[3]) chk(r_sed, c[1] ? SED ^ {32{c}} : {64'h0, SED[63:0] ^ {16{c}}});
  endtask

  task automatic bad(input logic [1:0] ec);
    int ok0;
    int er0;
    @(posedge clk);
    ok0 = ok_n;
    er0 = err_n;
    foreach (fr[i]) begin
      lk2.data  <= fr[i];
      lk2.valid <= 1'b1;
      lk2.last  <= i == fr.size() - 1;
      @(posedge clk);
      while (lk2.ready !== 1'b1) @(posedge clk);
    end
    // released line shows inverted data, never a stale octet
    lk2.valid <= 1'b0;
    lk2.last  <= 1'b0;
    lk2.data  <= ~lk2.data;
    repeat (3) @(negedge clk);
    chk(ok_n - ok0, 0);
    chk(err_n - er0, 1);
    chk(err_cd, ec);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #20000;
    mismatches++;
    end_sim();
  end

  initial begin
    lk2.data  = 8'h00;
    lk2.valid = 1'b0;
    lk2.last  = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (CASES[i]) send(CASES[i]);
    cfg <= 4'h0;
    fr = '{8'h42, 8'h0a, 8'h03, 8'h01, 8'h02, 8'h03};
    bad(amc_pkg::ERR_TYPE);
    fr = '{8'h40, 8'h0c, 8'h07, 8'h11};
    bad(amc_pkg::ERR_LEN);
    fr = '{8'h40, 8'h0b, 8'h03, 8'h01};
    bad(amc_pkg::ERR_ID);
    fr = '{8'h40, 8'h0a, 8'h03, 8'h01, 8'h02, 8'h03};
    bad(amc_pkg::ERR_MISSING);
    end_sim();
  end
endmodule // tb
